// ===== adcs_pkg.sv
/*
 * Constants, bus carrier and state type for the converter sequencer.
 * Assumes one 20 MHz clock and a byte-wide register port.
 */
package adcs_pkg;

  // ********************************
  // Widths and register offsets
  // ********************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int RES_W  = 10;

  localparam logic [15:0] OFF_RES_HIGH = 16'hFFC4;
  localparam logic [15:0] OFF_RES_LOW  = 16'hFFC5;
  localparam logic [15:0] OFF_MODE     = 16'hFFC6;
  localparam logic [15:0] OFF_START    = 16'hFFC7;
  localparam logic [15:0] OFF_CLK_STOP = 16'hFFFA;
  localparam logic [15:0] OFF_IRQ_REQ  = 16'hFFF7;
  localparam logic [15:0] OFF_IRQ_EN   = 16'hFFF4;
  localparam logic [15:0] OFF_PORT_MD  = 16'hFFDC;
  localparam logic [15:0] OFF_EDGE_SEL = 16'hFFF2;

  // ********************************
  // Field positions and reset values
  // ********************************
  localparam int BIT_CKS   = 7;
  localparam int BIT_TRIGGER_ENABLE  = 6;
  localparam int BIT_START = 7;
  localparam int BIT_STBY  = 4;
  localparam int BIT_IRQ   = 6;
  localparam int BIT_PFN   = 4;
  localparam int BIT_EDGE  = 4;

  localparam logic [7:0] MODE_RST  = 8'h30;
  localparam logic [1:0] MODE_ONES = 2'h3;
  localparam logic [6:0] START_ONE = 7'h7F;
  localparam logic [7:0] ALL_ONES  = 8'hFF;
  localparam logic [3:0] CH_AN1    = 4'h5;

  // ********************************
  // Timing counts in system clocks
  // ********************************
  localparam logic [5:0] PERIOD_SLOW = 6'd62;
  localparam logic [5:0] PERIOD_FAST = 6'd31;
  localparam logic [5:0] STEP_CYC    = 6'd3;
  localparam logic [5:0] SAR_SPAN    = 6'd30;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              we;
    logic              re;
  } adcs_bus_type;

  typedef enum logic {ST_IDLE, ST_CONV} adcs_state_type;

endpackage

// ===== adcs_sequencer.sv
/*
 * Conversion sequencer of a 10-bit successive approximation
 * converter: start by software or trigger pin, busy flag,
 * completion request, module standby and result holding.
 * Assumes a comparator input that is high while the analog
 * level is at or above the trial code, and a trigger pin that
 * is asynchronous to clk_in.
 */
// The implementer's own choices: the plain strobed port and the register addresses.

// What this block does
// - Standby bit 0 halts the converter, 1 runs it; resets to 1.
// - Conversion runs by successive approximation giving a 10-bit result.
// - Writing start flag 1 begins conversion; flag reads 1 while busy.
// - Start flag clears itself when conversion ends.
// - Each completion sets the conversion-end request flag.
// - Interrupt output asserts only while the enable bit is 1.
// - Trigger pin starts conversions only when function and enable bits are 1.
// - Selected trigger edge sets start flag and begins conversion.
// - Result registers survive reset.
// - Result stored and converter idle in the cycle the flag clears.
// - Channel code 0101 selects analog channel 1.
// - Writing start again after completion runs a fresh conversion.
// - Upper 8 result bits in high register, lowest 2 at top of low.
// - Writing start flag 0 stops a running conversion.
// - Trigger enable at 0, its reset value, ignores the pin.
// - Stored result stays unchanged until the next conversion ends.
module adcs_sequencer
  import adcs_pkg::*;
(
  input  wire logic           clk_in,
  input  wire logic           reset_in,
  input  wire adcs_bus_type   bus_in,
  input  wire logic           ext_trigger_pin_in,
  input  wire logic           comp_in,
  output logic [DATA_W-1:0]   rdata_out,
  output logic                conv_end_irq_out,
  output logic [RES_W-1:0]    trial_code_out,
  output logic [2:0]          analog_channel_out,
  output logic                channel_enable_out,
  output logic                converter_enable_out
);

  // ********************************
  // Register state
  // ********************************
  adcs_state_type   state;
  adcs_state_type   next_state;
  logic             cks;
  logic             trigger_enable;
  logic [3:0]       channel_select_field;
  logic             conv_end_irq_flag;
  logic             conv_end_irq_enable;
  logic             trigger_pin_function;
  logic             trigger_edge_select;
  logic [5:0]       cnt;
  logic [RES_W-1:0] bitmask;
  logic [RES_W-1:0] result;
  logic             trg_q1;
  logic             trg_q2;
  logic             trg_q3;
  logic             comp_q1;
  logic             comp_q2;

  // ********************************
  // Address decode
  // ********************************
  // Addresses are decoded in full; a write to any other
  // address is ignored and a read of it returns zero.
  wire wr_mode  = bus_in.we && (bus_in.addr == OFF_MODE);
  wire wr_start = bus_in.we && (bus_in.addr == OFF_START);
  wire wr_stop  = bus_in.we && (bus_in.addr == OFF_CLK_STOP);
  wire wr_ireq  = bus_in.we && (bus_in.addr == OFF_IRQ_REQ);
  wire wr_ien   = bus_in.we && (bus_in.addr == OFF_IRQ_EN);
  wire wr_pmd   = bus_in.we && (bus_in.addr == OFF_PORT_MD);
  wire wr_edge  = bus_in.we && (bus_in.addr == OFF_EDGE_SEL);

  // ********************************
  // Sequencing terms
  // ********************************
  // The standby bit gates the converter's clock, so the count
  // waits and every start is refused while it is 0; a stop still ends a conversion.
  wire run        = converter_enable_out;
  wire busy       = (state == ST_CONV);
  wire conversion_start_flag = busy;
  wire trig_armed = trigger_pin_function && trigger_enable;
  wire rise_seen  = trg_q2 && !trg_q3;
  wire fall_seen  = !trg_q2 && trg_q3;
  wire edge_hit   = trigger_edge_select ? rise_seen : fall_seen;
  wire sw_start   = run && wr_start && bus_in.wdata[BIT_START];
  wire sw_stop    = wr_start && !bus_in.wdata[BIT_START];
  wire hw_start   = run && trig_armed && edge_hit;
  wire start      = !busy && (sw_start || hw_start);

  // A slow start loads 61 and a fast one 30; the count runs
  // down once per clock while running, and the decision at
  // zero is also the finish, so the flag clears after 62 or
  // 31 clocks. Standby stops the count, pausing the work.
  // A bit is decided every third clock in the last thirty, so
  // the synchronised comparator has settled on each trial.
  wire in_sar     = cnt < SAR_SPAN;
  wire on_step    = (cnt % STEP_CYC) == 6'd0;
  wire decide     = busy && run && in_sar && on_step;
  wire finish     = decide && (cnt == 6'd0);
  // Completion wins over a stop written in the same cycle.
  wire abort      = busy && sw_stop && !finish;

  wire [RES_W-1:0] kept_code = comp_q2 ? trial_code_out : (trial_code_out & ~bitmask);
  wire [RES_W-1:0] next_mask = bitmask >> 1;
  wire [RES_W-1:0] next_trial = kept_code | next_mask;
  wire [5:0] load_cnt = cks ? (PERIOD_FAST - 6'd1) : (PERIOD_SLOW - 6'd1);

  assign next_state = start ? ST_CONV : ((finish || abort) ? ST_IDLE : state);

  // The hardware set wins over a software clear of the flag.
  wire clr_irq  = wr_ireq && !bus_in.wdata[BIT_IRQ];
  wire next_irq = finish || (conv_end_irq_flag && !clr_irq);
  wire next_ien = wr_ien ? bus_in.wdata[BIT_IRQ] : conv_end_irq_enable;

  // Channel codes 01xx and 10xx pick one of eight inputs.
  wire       ch_valid = channel_select_field[3] ^ channel_select_field[2];
  wire [2:0] ch_num   = {channel_select_field[3], channel_select_field[1:0]};
  wire       an1_code = (channel_select_field == CH_AN1);

  // ********************************
  // Read data selection
  // ********************************
  // Reserved bits read as ones where the register keeps them
  // so, and the coined control bits read zero around them.
  wire [7:0] rd_mode  = {cks, trigger_enable, MODE_ONES, channel_select_field};
  wire [7:0] rd_start = {conversion_start_flag, START_ONE};
  wire [7:0] rd_stop  = {ALL_ONES[7:5], converter_enable_out, ALL_ONES[3:0]};
  wire [7:0] rd_high  = result[RES_W-1:2];
  wire [7:0] rd_low   = {result[1:0], 6'h00};
  wire [7:0] rd_ireq  = {1'b0, conv_end_irq_flag, 6'h00};
  wire [7:0] rd_ien   = {1'b0, conv_end_irq_enable, 6'h00};
  wire [7:0] rd_pmd   = {3'h0, trigger_pin_function, 4'h0};
  wire [7:0] rd_edge  = {3'h0, trigger_edge_select, 4'h0};
  wire [7:0] rd_mux =
    (bus_in.addr == OFF_MODE)     ? rd_mode  :
    (bus_in.addr == OFF_START)    ? rd_start :
    (bus_in.addr == OFF_CLK_STOP) ? rd_stop  :
    (bus_in.addr == OFF_RES_HIGH) ? rd_high  :
    (bus_in.addr == OFF_RES_LOW)  ? rd_low   :
    (bus_in.addr == OFF_IRQ_REQ)  ? rd_ireq  :
    (bus_in.addr == OFF_IRQ_EN)   ? rd_ien   :
    (bus_in.addr == OFF_PORT_MD)  ? rd_pmd   :
    (bus_in.addr == OFF_EDGE_SEL) ? rd_edge  : 8'h00;

  // ********************************
  // Pin synchronisers
  // ********************************
  // Trigger and comparator each pass two flops; only the
  // second stage feeds the edge detector or the decisions.
  // The edge flop resets low like the idle pin, so no false
  // rise appears when reset is released.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      trg_q1  <= 1'b0;
      trg_q2  <= 1'b0;
      trg_q3  <= 1'b0;
      comp_q1 <= 1'b0;
      comp_q2 <= 1'b0;
    end else begin
      trg_q1  <= ext_trigger_pin_in;
      trg_q2  <= trg_q1;
      trg_q3  <= trg_q2;
      comp_q1 <= comp_in;
      comp_q2 <= comp_q1;
    end
  end

  // ********************************
  // Control registers
  // ********************************
  // Mode writes are lost while the clock is stopped, as the
  // module itself is then frozen.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cks                  <= MODE_RST[BIT_CKS];
      trigger_enable       <= MODE_RST[BIT_TRIGGER_ENABLE];
      channel_select_field <= MODE_RST[3:0];
      converter_enable_out <= ALL_ONES[BIT_STBY];
      conv_end_irq_flag    <= 1'b0;
      conv_end_irq_enable  <= 1'b0;
      conv_end_irq_out     <= 1'b0;
      trigger_pin_function <= 1'b0;
      trigger_edge_select  <= 1'b0;
    end else begin
      if (wr_mode && run) begin
        cks                  <= bus_in.wdata[BIT_CKS];
        trigger_enable       <= bus_in.wdata[BIT_TRIGGER_ENABLE];
        channel_select_field <= bus_in.wdata[3:0];
      end
      if (wr_stop) begin
        converter_enable_out <= bus_in.wdata[BIT_STBY];
      end
      if (wr_pmd) begin
        trigger_pin_function <= bus_in.wdata[BIT_PFN];
      end
      if (wr_edge) begin
        trigger_edge_select <= bus_in.wdata[BIT_EDGE];
      end
      conv_end_irq_flag   <= next_irq;
      conv_end_irq_enable <= next_ien;
      conv_end_irq_out    <= next_irq && next_ien;
    end
  end

  // ********************************
  // Conversion sequencer
  // ********************************
  // A start reloads count, pointer and trial in one edge, so
  // a stopped conversion leaves nothing behind for the next.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state          <= ST_IDLE;
      cnt            <= 6'd0;
      bitmask        <= 10'h000;
      trial_code_out <= 10'h000;
    end else begin
      state <= next_state;
      if (start) begin
        cnt            <= load_cnt;
        bitmask        <= 10'h200;
        trial_code_out <= 10'h200;
      end else if (busy && run) begin
        cnt <= cnt - 6'd1;
        if (decide) begin
          bitmask        <= next_mask;
          trial_code_out <= next_trial;
        end
      end
    end
  end

  // Results have no reset so that they survive any reset but
  // power-up; they change only on a completed conversion.
  always_ff @(posedge clk_in) begin
    if (finish) begin
      result <= kept_code;
    end
  end

  // ********************************
  // Bus answer and mux outputs
  // ********************************
  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out          <= 8'h00;
      analog_channel_out <= 3'd0;
      channel_enable_out <= 1'b0;
    end else begin
      rdata_out          <= bus_in.re ? rd_mux : 8'h00;
      analog_channel_out <= ch_num;
      channel_enable_out <= ch_valid;
    end
  end

  // ********************************
  // Assertions
  // ********************************
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  standby_freeze_a: assert property (!run |=> $stable(cnt))
    else $error("counter moved in standby");
  sar_onehot_a: assert property (busy |-> $onehot0(bitmask) && cnt < PERIOD_SLOW)
    else $error("approximation pointer broken");
  sw_start_a: assert property (sw_start && !busy |=> busy && cnt == $past(load_cnt))
    else $error("software start not taken");
  busy_hold_a: assert property (busy && !finish && !abort |=> busy)
    else $error("start flag dropped early");
  finish_store_a: assert property (finish |=> !busy && result == $past(kept_code))
    else $error("completion did not store and idle");
  irq_set_a: assert property (finish |=> conv_end_irq_flag)
    else $error("request flag not set");
  irq_gate_a: assert property (conv_end_irq_out == (conv_end_irq_flag && conv_end_irq_enable))
    else $error("interrupt not gated by enable");
  trig_start_a: assert property (hw_start && !busy |=> busy)
    else $error("trigger edge did not start");
  trig_ignore_a: assert property (!trig_armed && !busy && !sw_start |=> !busy)
    else $error("start without a source");
  result_hold_a: assert property (!finish |=> $stable(result))
    else $error("result changed without completion");
  ch_one_a: assert property (an1_code |=> analog_channel_out == 3'd1 && channel_enable_out)
    else $error("channel 1 not selected");
  stop_conv_a: assert property (abort |=> !busy && (!conv_end_irq_flag || $past(conv_end_irq_flag)))
    else $error("stop did not halt conversion");
  low_read_a: assert property (bus_in.re && bus_in.addr == OFF_RES_LOW |=> rdata_out[5:0] == 6'h00)
    else $error("low result layout wrong");

  // Standby must pause the converter as a whole: no start
  // and no mode change may slip through while it is 0.
  standby_idle_a: assert property (!run && !busy |=> !busy)
    else $error("start taken in standby");
  mode_frozen_a: assert property (!run |=> $stable(channel_select_field) && $stable(cks))
    else $error("mode changed in standby");

  // Every start restarts the pointer at the top bit, whatever
  // a stopped conversion left behind.
  trial_load_a: assert property (start |=> trial_code_out == 10'h200 && bitmask == 10'h200)
    else $error("trial code not reloaded at start");
  flag_read_a: assert property (bus_in.re && bus_in.addr == OFF_START |=> rdata_out[BIT_START] == $past(busy))
    else $error("start flag read wrong");

  // The request flag moves only on completion or a clear.
  irq_hold_a: assert property (conv_end_irq_flag && !clr_irq |=> conv_end_irq_flag)
    else $error("request flag lost");
  irq_source_a: assert property (!conv_end_irq_flag && !finish |=> !conv_end_irq_flag)
    else $error("request flag set without completion");
  ch_off_a: assert property (!ch_valid |=> !channel_enable_out)
    else $error("channel enabled for a void code");

  // Main scenarios: both start sources, a stop, a restart and a pause.
  sw_run_c: cover property (sw_start ##[30:70] finish);
  trig_run_c: cover property (hw_start ##[30:70] finish);
  abort_c: cover property (abort);
  restart_c: cover property (finish ##[1:20] sw_start);
  pause_c: cover property (busy && !run);

endmodule

// ===== adcs_analog_model.sv
/*
 * Far-side model of the sequencer: the analog source on channel 1 and
 * the external trigger line. Assumes the sequencer's channel outputs.
 */
module adcs_analog_model
  import adcs_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic [RES_W-1:0] level_in,
  input  wire logic             trig_in,
  input  wire logic [RES_W-1:0] trial_code_in,
  input  wire logic [2:0]       analog_channel_in,
  input  wire logic             channel_enable_in,
  output logic                  comp_out,
  output logic                  ext_trigger_pin_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ********************************
  // Comparator and trigger line
  // ********************************
  // Only channel 1 carries a level; other inputs sit at ground, so they convert to 0.
  assign comp_out = channel_enable_in && (analog_channel_in == 3'h1) && (level_in >= trial_code_in);

  // The pin moves just after an edge, so its level always spans whole clocks.
  always_ff @(posedge clk_in) begin
    ext_trigger_pin_out <= trig_in;
  end
endmodule

// ===== tb.sv
/*
 * Self-checking bench of the converter sequencer: register tasks,
 * software and pin starts, stop, standby and reset retention.
 * Assumes the analog model file and the design package.
 */
module tb
  import adcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_in;
  logic              reset_in;
  adcs_bus_type      bus;
  logic              trig;
  logic              comp;
  logic              pin;
  logic              irq;
  logic              ch_en;
  logic              cen;
  logic [2:0]        ch;
  logic [RES_W-1:0]  level;
  logic [RES_W-1:0]  trial;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] d;
  int                n_fail;
  int                compares;

  adcs_sequencer i_adcs_sequencer (.clk_in(clk_in), .reset_in(reset_in), .bus_in(bus),
    .ext_trigger_pin_in(pin), .comp_in(comp), .rdata_out(rdata), .conv_end_irq_out(irq),
    .trial_code_out(trial), .analog_channel_out(ch), .channel_enable_out(ch_en),
    .converter_enable_out(cen));

  adcs_analog_model i_adcs_analog_model (.clk_in(clk_in), .level_in(level), .trig_in(trig),
    .trial_code_in(trial), .analog_channel_in(ch), .channel_enable_in(ch_en),
    .comp_out(comp), .ext_trigger_pin_out(pin));

  // ********************************
  // Access tasks and checks
  // ********************************
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_in);
    bus.addr <= a;
    bus.wdata <= v;
    bus.we <= 1'b1;
    @(posedge clk_in);
    bus.we <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rd(input logic [15:0] a);
    @(posedge clk_in);
    bus.addr <= a;
    bus.re <= 1'b1;
    @(posedge clk_in);
    bus.re <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    rd(a);
    chk(d, e);
  endtask

  task automatic res(input logic [9:0] e);
    rdc(OFF_RES_HIGH, e[9:2]);
    rdc(OFF_RES_LOW, {e[1:0], 6'h00});
  endtask

  // Polls the busy flag; the results are read only once it has cleared.
  task automatic wait_done();
    int i;
    i = 0;
    do begin
      rd(OFF_START);
      i++;
    end while (d[BIT_START] !== 1'b0 && i < 100);
    chk(d, 8'h7F);
  endtask

  task automatic final_report();
    if (n_fail == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ********************************
  // Clock, watchdog and tests
  // ********************************
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // The tests need about 400 clocks; 20000 leaves wide margin.
  initial begin
    #(20000 * 50);
    n_fail++;
    final_report();
  end

  initial begin
    reset_in = 1'b1;
    bus = '0;
    trig = 1'b0;
    level = 10'h2B6;
    n_fail = 0;
    compares = 0;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    rdc(OFF_MODE, MODE_RST);
    rdc(OFF_START, 8'h7F);
    rdc(OFF_CLK_STOP, ALL_ONES);
    rdc(16'h0000, 8'h00);
    chk(cen, 1'b1);
    chk({ch_en, ch}, 4'h0);
    wr(OFF_MODE, 8'h05);
    wr(OFF_IRQ_EN, 8'h40);
    chk({ch_en, ch}, 4'h9);
    wr(OFF_START, 8'h80);
    rdc(OFF_START, ALL_ONES);
    wait_done();
    rdc(OFF_IRQ_REQ, 8'h40);
    chk(irq, 1'b1);
    res(level);
    // Fast period with the request masked; the channel code stays 0101.
    wr(OFF_IRQ_REQ, 8'h00);
    wr(OFF_IRQ_EN, 8'h00);
    level = 10'h13C;
    wr(OFF_MODE, 8'h85);
    wr(OFF_START, 8'h80);
    wait_done();
    rdc(OFF_IRQ_REQ, 8'h40);
    chk(irq, 1'b0);
    res(level);
    // A stop leaves the request clear and the old result in place.
    wr(OFF_IRQ_REQ, 8'h00);
    level = 10'h3FF;
    wr(OFF_START, 8'h80);
    wr(OFF_START, 8'h00);
    rdc(OFF_START, 8'h7F);
    repeat (40) @(posedge clk_in);
    rdc(OFF_IRQ_REQ, 8'h00);
    res(10'h13C);
    // Only both enables together let a rising pin edge start a conversion.
    wr(OFF_EDGE_SEL, 8'h10);
    for (int k = 0; k < 4; k++) begin
      wr(OFF_MODE, k[0] ? 8'hC5 : 8'h85);
      wr(OFF_PORT_MD, k[1] ? 8'h10 : 8'h00);
      trig <= 1'b1;
      repeat (6) @(posedge clk_in);
      rd(OFF_START);
      chk(d[BIT_START], k == 3);
      trig <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
    wait_done();
    res(level);
    wr(OFF_EDGE_SEL, 8'h00);
    trig <= 1'b1;
    repeat (6) @(posedge clk_in);
    rdc(OFF_START, 8'h7F);
    trig <= 1'b0;
    repeat (6) @(posedge clk_in);
    rdc(OFF_START, ALL_ONES);
    wait_done();
    // Standby refuses a start; the start after leaving it waits ten clocks.
    wr(OFF_CLK_STOP, 8'hEF);
    rdc(OFF_CLK_STOP, 8'hEF);
    chk(cen, 1'b0);
    wr(OFF_START, 8'h80);
    rdc(OFF_START, 8'h7F);
    wr(OFF_CLK_STOP, ALL_ONES);
    repeat (10) @(posedge clk_in);
    chk(cen, 1'b1);
    level = 10'h0A1;
    wr(OFF_START, 8'h80);
    wait_done();
    // A reset in mid-conversion clears control but keeps the result.
    wr(OFF_START, 8'h80);
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    rdc(OFF_START, 8'h7F);
    rdc(OFF_MODE, MODE_RST);
    res(10'h0A1);
    wr(OFF_CLK_STOP, 8'hEF);
    final_report();
  end
endmodule
